// ===== rtl/fms_pkg.sv
// constants and types shared by the fan mode, spin-up and fault-mask block
package fms_pkg;

    // ****************************************************************
    // geometry
    // ****************************************************************
    localparam int NFAN   = 4;
    localparam int DRV_W  = 9;
    localparam int TACH_W = 11;

    // ****************************************************************
    // register port selects and field positions
    // ****************************************************************
    localparam logic [2:0] REG_FAULT = 3'h0;   // status [7:4], mask [3:0]
    localparam logic [2:0] REG_CFG0  = 3'h1;   // fan 1..4 config at 1..4
    localparam int FLT_STAT_LSB = 4;
    localparam int CFG_MODE_BIT = 7;
    localparam int CFG_SPIN_MSB = 6;
    localparam int CFG_SPIN_LSB = 5;
    localparam logic [1:0] SPIN_OFF = 2'h0;
    localparam logic [1:0] SPIN_ON  = 2'h1;
    localparam logic [7:0] CFG_RST  = 8'h00;
    localparam logic [3:0] MASK_RST = 4'h0;

    // ****************************************************************
    // drive levels and timing
    // ****************************************************************
    localparam logic [DRV_W-1:0] DRV_FULL = 9'h1ff;
    localparam logic [DRV_W-1:0] DRV_ZERO = 9'h000;
    localparam int CLK_KHZ       = 40000;
    localparam int SPIN_MAX_MS   = 500;
    localparam int SPIN_MAX_CYC  = CLK_KHZ * SPIN_MAX_MS;
    localparam int RAMP_STEP_US  = 100;
    localparam int RAMP_STEP_CYC = (CLK_KHZ * RAMP_STEP_US) / 1000;

    // ****************************************************************
    // per-fan drive state
    // ****************************************************************
    typedef enum logic [2:0] {
        CH_DIRECT = 3'b001,
        CH_LOOP   = 3'b010,
        CH_SPIN   = 3'b100
    } fms_ch_state_type;

endpackage

// ===== rtl/fms_channel.sv
// one fan's drive: direct voltage, closed speed loop and spin-up kick
`timescale 1ns/1ps
`default_nettype none
module fms_channel
    import fms_pkg::*;
#(
    parameter int SPIN_CYC = SPIN_MAX_CYC
) (
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic              speed_loop_select,
    input  wire logic [1:0]        spin_code,
    input  wire logic [DRV_W-1:0]  tgt_drive,
    input  wire logic [TACH_W-1:0] tgt_tach,
    input  wire logic [TACH_W-1:0] meas_tach,
    input  wire logic              tach_pulse,
    input  wire logic              locked_rotor,
    input  wire logic              fault_off,
    input  wire logic              ramp_tick,
    output logic [DRV_W-1:0]       drive_q
);
    localparam int CW = $clog2(SPIN_CYC + 1);

    fms_ch_state_type  state_q;
    logic [CW-1:0]     timer_q;
    logic [1:0]        pulses_q;
    logic              lr_prev_q;
    logic              spin_start;
    logic              spin_done;

    // ****************************************************************
    // spin-up entry and exit conditions
    // ****************************************************************
    assign spin_start = (spin_code != SPIN_OFF) && (drive_q == DRV_ZERO) &&
                        (tgt_drive != DRV_ZERO) && (tgt_drive < DRV_FULL);
    assign spin_done  = (tach_pulse && pulses_q == 2'h1) ||
                        (lr_prev_q && !locked_rotor) ||
                        (timer_q == CW'(SPIN_CYC - 1));

    // state and drive level
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= CH_DIRECT;
            drive_q <= DRV_ZERO;
        end else if (fault_off) begin
            state_q <= CH_DIRECT;
            drive_q <= DRV_ZERO;
        end else begin
            case (state_q)
                CH_DIRECT: begin
                    if (speed_loop_select) begin
                        state_q <= CH_LOOP;
                    end else if (spin_start) begin
                        state_q <= CH_SPIN;
                        drive_q <= DRV_FULL;
                    end else begin
                        drive_q <= tgt_drive;
                    end
                end
                CH_SPIN: begin
                    if (spin_done) begin
                        state_q <= CH_DIRECT;
                        drive_q <= tgt_drive;
                    end else begin
                        drive_q <= DRV_FULL;
                    end
                end
                CH_LOOP: begin
                    if (!speed_loop_select) begin
                        state_q <= CH_DIRECT;
                    end else if (ramp_tick) begin
                        // higher count means slower fan, so push harder
                        if (meas_tach > tgt_tach && drive_q != DRV_FULL) begin
                            drive_q <= drive_q + 9'h001;
                        end else if (meas_tach < tgt_tach &&
                                     drive_q != DRV_ZERO) begin
                            drive_q <= drive_q - 9'h001;
                        end
                    end
                end
                default: begin
                    state_q <= CH_DIRECT;
                    drive_q <= DRV_ZERO;
                end
            endcase
        end
    end

    // spin-up timer, pulse counter and locked-rotor history
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            timer_q   <= '0;
            pulses_q  <= 2'h0;
            lr_prev_q <= 1'b0;
        end else begin
            lr_prev_q <= locked_rotor;
            if (state_q != CH_SPIN) begin
                timer_q  <= '0;
                pulses_q <= 2'h0;
            end else begin
                timer_q <= timer_q + CW'(1);
                if (tach_pulse && pulses_q != 2'h3) begin
                    pulses_q <= pulses_q + 2'h1;
                end
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_spin_entry;
        state_q == CH_DIRECT && !fault_off && !speed_loop_select &&
        spin_start;
    endsequence

    sequence s_spin_leave;
        state_q == CH_SPIN && !fault_off && spin_done;
    endsequence

    a_direct_drive: assert property (@(posedge mclk) disable iff (!rstn)
        state_q == CH_DIRECT && !fault_off && !speed_loop_select &&
        !spin_start |=> drive_q == $past(tgt_drive))
        else $error("direct mode drive does not follow target");

    a_loop_raise: assert property (@(posedge mclk) disable iff (!rstn)
        state_q == CH_LOOP && !fault_off && speed_loop_select && ramp_tick &&
        meas_tach > tgt_tach && drive_q != DRV_FULL
        |=> drive_q == $past(drive_q) + 9'h001)
        else $error("speed loop did not raise drive");

    a_loop_keep: assert property (@(posedge mclk) disable iff (!rstn)
        state_q == CH_DIRECT && !fault_off && speed_loop_select
        |=> state_q == CH_LOOP && $stable(drive_q))
        else $error("loop entry did not start from present drive");

    a_spin_full: assert property (@(posedge mclk) disable iff (!rstn)
        s_spin_entry |=> drive_q == DRV_FULL && state_q == CH_SPIN)
        else $error("spin-up did not apply full drive");

    a_spin_hold: assert property (@(posedge mclk) disable iff (!rstn)
        state_q == CH_SPIN && !fault_off && !spin_done |=> drive_q == DRV_FULL)
        else $error("full drive dropped during spin-up");

    a_spin_limit: assert property (@(posedge mclk) disable iff (!rstn)
        state_q == CH_SPIN |-> timer_q < CW'(SPIN_CYC))
        else $error("spin-up ran past its limit");

    a_spin_exit: assert property (@(posedge mclk) disable iff (!rstn)
        s_spin_leave |=> drive_q == $past(tgt_drive) && state_q == CH_DIRECT)
        else $error("spin-up exit did not load target drive");

    a_spin_off: assert property (@(posedge mclk) disable iff (!rstn)
        state_q == CH_DIRECT && spin_code == SPIN_OFF |=> state_q != CH_SPIN)
        else $error("spin-up started while disabled");

endmodule
`default_nettype wire

// ===== rtl/fms_top.sv
// fan fault masking, per-fan mode select and spin-up control for four fans
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - mask bit keeps fault off shared failure
// - mode 0 drives target drive voltage directly
// - mode 1 steers drive to target tach count
// - loop entry ramps from present drive voltage
// - mode 0 rise from zero gets full-scale kick
// - full drive held until two pulses, rotor clear
// - spin-up ends on fixed SPIN_CYC timeout
// - spin-up end loads target drive voltage
// - fault status sticky, cleared by host read
// - code 00 off, 01 on, half second
module fms_top
    import fms_pkg::*;
#(
    parameter int SPIN_CYC = SPIN_MAX_CYC,
    parameter int RAMP_CYC = RAMP_STEP_CYC
) (
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire logic                   startup_kick_strap,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [2:0]             reg_sel,
    input  wire logic [7:0]             reg_wdata,
    output logic [7:0]                  reg_rdata_q,
    input  wire logic [NFAN-1:0]        fault_evt,
    input  wire logic [NFAN-1:0]        tgt_wr,
    input  wire logic [NFAN*DRV_W-1:0]  tgt_drive,
    input  wire logic [NFAN*TACH_W-1:0] tgt_tach,
    input  wire logic [NFAN*TACH_W-1:0] meas_tach,
    input  wire logic [NFAN-1:0]        tach_pin,
    input  wire logic [NFAN-1:0]        locked_rotor,
    output logic [NFAN*DRV_W-1:0]       drive_out,
    output logic                        fan_fail_q
);
    localparam int RW = $clog2(RAMP_CYC + 1);

    logic [7:0]      cfg_q [NFAN];
    logic [NFAN-1:0] status_q;
    logic [NFAN-1:0] mask_q;
    logic [NFAN-1:0] fault_off_q;
    logic [NFAN-1:0] tach_s1_q;
    logic [NFAN-1:0] tach_s2_q;
    logic [NFAN-1:0] tach_s3_q;
    logic [NFAN-1:0] tach_pulse;
    logic            strap_s1_q;
    logic            strap_s2_q;
    logic [2:0]      strap_wait_q;
    logic [RW-1:0]   ramp_cnt_q;
    logic            ramp_tick_q;
    logic            rd_fault;

    assign rd_fault   = reg_rd && (reg_sel == REG_FAULT);
    assign tach_pulse = tach_s2_q & ~tach_s3_q;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // tach pins and strap pass two flops before any logic sees them
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tach_s1_q  <= '0;
            tach_s2_q  <= '0;
            tach_s3_q  <= '0;
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
        end else begin
            tach_s1_q  <= tach_pin;
            tach_s2_q  <= tach_s1_q;
            tach_s3_q  <= tach_s2_q;
            strap_s1_q <= startup_kick_strap;
            strap_s2_q <= strap_s1_q;
        end
    end

    // ****************************************************************
    // register file
    // ****************************************************************
    // configuration: strap loads the spin-up field for three edges after
    // reset; the last load is the first to see the synchronised pin
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strap_wait_q <= 3'h0;
            for (int i = 0; i < NFAN; i++) begin
                cfg_q[i] <= CFG_RST;
            end
        end else begin
            strap_wait_q <= {strap_wait_q[1:0], 1'b1};
            for (int i = 0; i < NFAN; i++) begin
                if (reg_wr && reg_sel == REG_CFG0 + 3'(i)) begin
                    cfg_q[i] <= reg_wdata;
                end else if (!strap_wait_q[2]) begin
                    cfg_q[i][CFG_SPIN_MSB:CFG_SPIN_LSB] <=
                        strap_s2_q ? SPIN_ON : SPIN_OFF;
                end
            end
        end
    end

    // fault mask bits, low nibble of the fault register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= MASK_RST;
        end else if (reg_wr && reg_sel == REG_FAULT) begin
            mask_q <= reg_wdata[NFAN-1:0];
        end
    end

    // sticky status: a new fault wins over the read that clears
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            status_q <= '0;
        end else begin
            status_q <= (rd_fault ? '0 : status_q) | fault_evt;
        end
    end

    // drive stays cut after a fault until a new target is written
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            fault_off_q <= '0;
        end else begin
            fault_off_q <= (fault_off_q & ~tgt_wr) | fault_evt;
        end
    end

    // read data, captured before the read clears status
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            if (reg_sel == REG_FAULT) begin
                reg_rdata_q <= {status_q, mask_q};
            end else if (reg_sel >= REG_CFG0 &&
                         reg_sel < REG_CFG0 + 3'(NFAN)) begin
                reg_rdata_q <= cfg_q[2'(reg_sel - REG_CFG0)];
            end else begin
                reg_rdata_q <= 8'h00;   // unmapped select
            end
        end
    end

    // shared failure output only sees unmasked latched faults
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            fan_fail_q <= 1'b0;
        end else begin
            fan_fail_q <= |(status_q & ~mask_q);
        end
    end

    // ****************************************************************
    // ramp rate tick for the speed loop
    // ****************************************************************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ramp_cnt_q  <= '0;
            ramp_tick_q <= 1'b0;
        end else begin
            ramp_tick_q <= (ramp_cnt_q == RW'(RAMP_CYC - 1));
            if (ramp_cnt_q == RW'(RAMP_CYC - 1)) begin
                ramp_cnt_q <= '0;
            end else begin
                ramp_cnt_q <= ramp_cnt_q + RW'(1);
            end
        end
    end

    // ****************************************************************
    // per-fan channels
    // ****************************************************************
    for (genvar g = 0; g < NFAN; g++) begin : g_fan
        fms_channel #(
            .SPIN_CYC (SPIN_CYC)
        ) u_ch (
            .mclk              (mclk),
            .rstn              (rstn),
            .speed_loop_select (cfg_q[g][CFG_MODE_BIT]),
            .spin_code         (cfg_q[g][CFG_SPIN_MSB:CFG_SPIN_LSB]),
            .tgt_drive         (tgt_drive[g*DRV_W +: DRV_W]),
            .tgt_tach          (tgt_tach[g*TACH_W +: TACH_W]),
            .meas_tach         (meas_tach[g*TACH_W +: TACH_W]),
            .tach_pulse        (tach_pulse[g]),
            .locked_rotor      (locked_rotor[g]),
            .fault_off         (fault_off_q[g]),
            .ramp_tick         (ramp_tick_q),
            .drive_q           (drive_out[g*DRV_W +: DRV_W])
        );
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_fail_masked: assert property (@(posedge mclk) disable iff (!rstn)
        (status_q & ~mask_q) == '0 |=> !fan_fail_q)
        else $error("masked or absent fault raised failure output");

    a_fail_raised: assert property (@(posedge mclk) disable iff (!rstn)
        (status_q & ~mask_q) != '0 |=> fan_fail_q)
        else $error("unmasked fault did not raise failure output");

    a_status_sticky: assert property (@(posedge mclk) disable iff (!rstn)
        status_q[0] && !rd_fault |=> status_q[0] [*1] ##0 $stable(status_q[0]))
        else $error("fault status dropped without a read");

    a_read_clears: assert property (@(posedge mclk) disable iff (!rstn)
        rd_fault && fault_evt == '0 |=> status_q == '0)
        else $error("read did not clear fault status");

    a_set_wins: assert property (@(posedge mclk) disable iff (!rstn)
        rd_fault && fault_evt[1]
        |=> status_q[1] && reg_rdata_q[5] == $past(status_q[1]))
        else $error("fault lost in the cycle of a clearing read");

    a_masked_cut: assert property (@(posedge mclk) disable iff (!rstn)
        fault_evt[0] && mask_q[0] ##1 !tgt_wr[0] && !rd_fault
        |=> drive_out[DRV_W-1:0] == DRV_ZERO && status_q[0])
        else $error("masked fault did not cut drive");

endmodule
`default_nettype wire

// ===== tb/fms_fan_model.sv
// behavioural four-fan model: tach pulses while spin_en and driven, locked-rotor level
`timescale 1ns/1ps
`default_nettype none
module fms_fan_model
    import fms_pkg::*;
#(
    parameter int HALF = 3
) (
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic [NFAN*DRV_W-1:0] drive_out,
    input  wire logic [NFAN-1:0]       spin_en,
    input  wire logic [NFAN-1:0]       lock_req,
    output logic [NFAN-1:0]            tach_pin,
    output logic [NFAN-1:0]            locked_rotor
);
    // ****************************************************************
    // rotation
    // ****************************************************************
    int cnt [NFAN];

    // tach toggles only while the fan turns; a stopped fan idles low
    always_ff @(posedge mclk or negedge rstn) begin
        for (int i = 0; i < NFAN; i++) begin
            if (!rstn) begin
                cnt[i] <= 0;
                tach_pin[i] <= 1'b0;
            end else if (spin_en[i] && drive_out[i*DRV_W +: DRV_W] != 0) begin
                cnt[i] <= (cnt[i] == HALF - 1) ? 0 : cnt[i] + 1;
                if (cnt[i] == HALF - 1) tach_pin[i] <= ~tach_pin[i];
            end else begin
                cnt[i] <= 0;
                tach_pin[i] <= 1'b0;
            end
        end
    end

    // locked-rotor indication follows the stall request one cycle late
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) locked_rotor <= '0;
        else locked_rotor <= lock_req;
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the fan mode, spin-up and fault-mask block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fms_pkg::*;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic                   mclk = 1'b0;
    logic                   rstn = 1'b0;
    logic                   strap = 1'b0;
    logic                   reg_wr = 1'b0;
    logic                   reg_rd = 1'b0;
    logic [2:0]             reg_sel = 3'h0;
    logic [7:0]             reg_wdata = 8'h00;
    logic [7:0]             reg_rdata_q;
    logic [NFAN-1:0]        fault_evt = '0;
    logic [NFAN-1:0]        tgt_wr = '0;
    logic [NFAN*DRV_W-1:0]  tgt_drive = '0;
    logic [NFAN*TACH_W-1:0] tgt_tach = '0;
    logic [NFAN*TACH_W-1:0] meas_tach = '0;
    logic [NFAN-1:0]        tach_pin;
    logic [NFAN-1:0]        locked_rotor;
    logic [NFAN*DRV_W-1:0]  drive_out;
    logic                   fan_fail_q;
    logic [NFAN-1:0]        spin_en = '0;
    logic [NFAN-1:0]        lock_req = '0;
    int                     error_cnt = 0;
    int                     samples_checked = 0;
    localparam int SPIN = 50;

    // clock of 25 ns period
    always #12.5 mclk = ~mclk;

    fms_top #(.SPIN_CYC(SPIN), .RAMP_CYC(4)) dut_u (
        .mclk(mclk), .rstn(rstn), .startup_kick_strap(strap),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .fault_evt(fault_evt), .tgt_wr(tgt_wr), .tgt_drive(tgt_drive),
        .tgt_tach(tgt_tach), .meas_tach(meas_tach), .tach_pin(tach_pin),
        .locked_rotor(locked_rotor), .drive_out(drive_out),
        .fan_fail_q(fan_fail_q));

    fms_fan_model fan_u (
        .mclk(mclk), .rstn(rstn), .drive_out(drive_out), .spin_en(spin_en),
        .lock_req(lock_req), .tach_pin(tach_pin),
        .locked_rotor(locked_rotor));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp9(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [8:0] drv(input int i);
        return drive_out[i*DRV_W +: DRV_W];
    endfunction

    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_sel <= s;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] s, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_sel <= s;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask

    // new target drive with its write strobe
    task automatic set_tgt(input int i, input logic [8:0] v);
        @(posedge mclk);
        tgt_drive[i*DRV_W +: DRV_W] <= v;
        tgt_wr[i] <= 1'b1;
        @(posedge mclk);
        tgt_wr[i] <= 1'b0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // wait until a fan leaves full-scale drive, bounded
    task automatic wait_off(input int i, input int lim, output int n);
        n = 0;
        #1;
        while (drv(i) === DRV_FULL && n < lim) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic pulse_fault(input int i);
        @(posedge mclk);
        fault_evt[i] <= 1'b1;
        @(posedge mclk);
        fault_evt[i] <= 1'b0;
    endtask

    // ****************************************************************
    // watchdog and tests
    // ****************************************************************
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        final_report();
    end

    initial begin
        logic [7:0] r;
        logic [8:0] d1;
        logic [8:0] d2;
        int n;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        cyc(3);
        // reset values and register access
        rd(REG_FAULT, r); cmp8(r, 8'h00);
        for (int i = 1; i <= 4; i++) begin
            rd(3'(i), r); cmp8(r, 8'h00);
        end
        wr(3'h2, 8'h1f);
        rd(3'h2, r); cmp8(r, 8'h1f);
        wr(3'h5, 8'hff);
        rd(3'h5, r); cmp8(r, 8'h00);
        wr(REG_FAULT, 8'hf1);
        rd(REG_FAULT, r); cmp8(r, 8'h01);
        $display("test registers done");
        // code 00: rise from zero goes straight to target
        set_tgt(0, 9'h080);
        cyc(1); cmp9(drv(0), 9'h080);
        $display("test direct done");
        // spin-up ended by two tach pulses
        wr(3'h2, 8'h20);
        set_tgt(1, 9'h040);
        cyc(1); cmp9(drv(1), DRV_FULL);
        cyc(10); cmp9(drv(1), DRV_FULL);
        spin_en[1] <= 1'b1;
        wait_off(1, 30, n);
        cmp9(drv(1), 9'h040);
        $display("test spin tach done");
        // spin-up ended by locked rotor clearing
        lock_req[2] <= 1'b1;
        wr(3'h3, 8'h20);
        set_tgt(2, 9'h030);
        cyc(6); cmp9(drv(2), DRV_FULL);
        lock_req[2] <= 1'b0;
        wait_off(2, 8, n);
        cmp9(drv(2), 9'h030);
        $display("test spin lock done");
        // spin-up ended by timeout
        wr(3'h4, 8'h20);
        set_tgt(3, 9'h1fe);
        wait_off(3, 100, n);
        cmp1(n >= SPIN - 5 && n <= SPIN + 5, 1'b1);
        cmp9(drv(3), 9'h1fe);
        $display("test spin timeout done");
        // masked fault: status and drive cut, failure output quiet
        pulse_fault(0);
        cyc(2);
        cmp1(fan_fail_q, 1'b0);
        cmp9(drv(0), DRV_ZERO);
        rd(REG_FAULT, r); cmp8(r, 8'h11);
        rd(REG_FAULT, r); cmp8(r, 8'h01);
        cmp9(drv(0), DRV_ZERO);
        set_tgt(0, 9'h080);
        cyc(2); cmp9(drv(0), 9'h080);
        // unmasked fault raises failure until the status is read
        pulse_fault(2);
        cyc(2);
        cmp1(fan_fail_q, 1'b1);
        cyc(5);
        rd(REG_FAULT, r); cmp8(r, 8'h41);
        cyc(2); cmp1(fan_fail_q, 1'b0);
        // fault and clearing read in one cycle: the new fault survives
        fork
            pulse_fault(1);
            rd(REG_FAULT, r);
        join
        cmp8(r, 8'h01);
        rd(REG_FAULT, r); cmp8(r, 8'h21);
        $display("test fault mask done");
        // closed loop: ramp from present drive toward tach target
        @(posedge mclk);
        tgt_tach[0 +: TACH_W] <= 11'h100;
        meas_tach[0 +: TACH_W] <= 11'h200;
        wr(3'h1, 8'h80);
        cyc(40);
        d1 = drv(0);
        cmp1(d1 > 9'h080 && d1 <= 9'h08c, 1'b1);
        @(posedge mclk);
        meas_tach[0 +: TACH_W] <= 11'h080;
        cyc(80);
        d2 = drv(0);
        cmp1(d2 < d1, 1'b1);
        @(posedge mclk);
        meas_tach[0 +: TACH_W] <= 11'h100;
        cyc(8);
        d2 = drv(0);
        cyc(20); cmp9(drv(0), d2);
        $display("test loop done");
        // second reset with the strap open selects spin-up code 01
        @(posedge mclk);
        strap <= 1'b1;
        rstn <= 1'b0;
        cyc(3);
        @(posedge mclk);
        rstn <= 1'b1;
        cyc(3);
        for (int i = 1; i <= 4; i++) begin
            rd(3'(i), r); cmp8(r, 8'h20);
        end
        $display("test strap done");
        final_report();
    end
endmodule
`default_nettype wire
